// ### hdl/dpct_pkg.sv
// Package for the dual prescaled counter/timer block.
// Assumes a single system clock; used by all design files under hdl/.
package dpct_pkg;

  // ********************************************************************
  // Register map (word addresses on the plain register port)
  // ********************************************************************
  localparam logic [3:0] ADDR_MODE    = 4'h0;  // Timer mode register
  localparam logic [3:0] ADDR_RELOAD0 = 4'h1;  // Counter 0 initial value
  localparam logic [3:0] ADDR_RELOAD1 = 4'h2;  // Counter 1 initial value
  localparam logic [3:0] ADDR_PRE0    = 4'h3;  // Prescaler 0 setup
  localparam logic [3:0] ADDR_PRE1    = 4'h4;  // Prescaler 1 setup
  localparam logic [3:0] ADDR_CTRL    = 4'h5;  // Start/stop/load commands
  localparam logic [3:0] ADDR_STATUS  = 4'h6;  // Sticky events, write one clears
  localparam logic [3:0] ADDR_MASK    = 4'h7;  // Interrupt mask

  // ********************************************************************
  // Field positions
  // ********************************************************************
  // Mode register
  localparam int MODE_TOUT_LO  = 0;  // Timer output select, 2 bits
  localparam int MODE_EXT_LO   = 2;  // External input use, 2 bits
  localparam int MODE_RETRIG   = 4;  // Trigger retriggerable
  localparam int MODE_CASCADE  = 5;  // Counter 0 output feeds counter 1
  localparam int MODE_T1_EXT   = 6;  // Counter 1 source external
  localparam int MODE_TOUT_EN  = 7;  // Port line drives timer output
  // Prescaler register
  localparam int PRE_DIV_LO    = 0;  // 6-bit divider, 0 means 64
  localparam int PRE_CONT      = 6;  // Continuous (modulo-n) mode
  // Control register, command bits per counter n at 2n and 2n+1
  localparam int CTRL_LOAD     = 0;  // Load initial value and enable
  localparam int CTRL_RUN      = 1;  // Level: counting enabled

  // ********************************************************************
  // Encodings and widths
  // ********************************************************************
  localparam logic [1:0] TOUT_SEL_T0  = 2'h0;
  localparam logic [1:0] TOUT_SEL_T1  = 2'h1;
  localparam logic [1:0] TOUT_SEL_CLK = 2'h2;
  localparam logic [1:0] EXT_CLOCK    = 2'h0;
  localparam logic [1:0] EXT_TRIGGER  = 2'h1;
  localparam logic [1:0] EXT_GATE     = 2'h2;
  localparam int         CNT_W        = 8;
  localparam int         PRE_W        = 6;
  localparam int         INT_DIV      = 4;   // Internal clock divided by four
  localparam logic [7:0] RESET_BYTE   = 8'h00;

endpackage : dpct_pkg

// ### hdl/dpct_prescaler.sv
// Programmable divide-by-1..64 prescaler.
// Assumes tick_in is a one-cycle pulse in the clk_sys_in domain.
`timescale 1ns/1ps
module dpct_prescaler
  import dpct_pkg::*;
#(
  parameter int W = PRE_W
) (
  input  wire logic         clk_sys_in,
  input  wire logic         reset_n_in,
  input  wire logic         clear_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio_in,
  output logic              pulse_out
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire          wrap;

  // ******************************************************************
  // Divider: a ratio of zero wraps at the full 2**W
  // ******************************************************************
  assign wrap      = tick_in && (cnt_q == ratio_in - W'(1));
  assign cnt_d     = clear_in ? '0 : (wrap ? '0 : cnt_q + W'(tick_in));
  assign pulse_out = wrap && !clear_in;

  // Count state, not visible to software
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : dpct_prescaler

// ### hdl/dpct_counter.sv
// One 8-bit down-counter with reload, single-pass and continuous modes.
// Assumes dec_in is a one-cycle pulse from the prescaler.
`timescale 1ns/1ps
module dpct_counter
  import dpct_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk_sys_in,
  input  wire logic         reset_n_in,
  input  wire logic         load_in,
  input  wire logic         run_in,
  input  wire logic         cont_in,
  input  wire logic         dec_in,
  input  wire logic [W-1:0] init_in,
  output logic [W-1:0]      count_out,
  output logic              eoc_out,
  output logic              running_out
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         run_q;
  logic         run_d;
  logic         eoc_q;
  wire          at_end;

  // ******************************************************************
  // Decrement; a load of zero counts the full 2**W steps
  // ******************************************************************
  assign at_end  = run_q && dec_in && (count_q == W'(1));
  assign count_d = load_in ? init_in :
                   at_end  ? (cont_in ? init_in : '0) :
                   (run_q && dec_in) ? count_q - W'(1) : count_q;
  // Stop keeps the count so a later start continues from it
  // The run level from the top clears one cycle after end of count; eoc_q
  // bridges that cycle so a finished single pass cannot restart by itself
  assign run_d   = load_in ? 1'b1 :
                   ((at_end || eoc_q) && !cont_in) ? 1'b0 : run_in;

  // Counter state
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      count_q <= '0;
      run_q   <= 1'b0;
      eoc_q   <= 1'b0;
    end else begin
      count_q <= count_d;
      run_q   <= run_d;
      eoc_q   <= at_end && !load_in;
    end
  end

  assign count_out   = count_q;
  assign eoc_out     = eoc_q;
  assign running_out = run_q;

endmodule : dpct_counter

// ### hdl/dpct_timers.sv
// Two prescaled 8-bit counter/timers with external input and timer output.
// Assumes a plain register port in the clk_sys_in domain, synchronous pins.
// Software owns every register through a one-cycle strobe port; nothing
// here makes the master wait. The timer pin is shared: it is an input only
// while the output driver is off, so one mode write decides its direction.
// Counter interrupts are levels from sticky status bits and their mask.
`timescale 1ns/1ps
module dpct_timers
  import dpct_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output logic [7:0]      reg_rdata_out,
  input  wire logic       port3_line6_in,
  output logic            port3_line6_out,
  output logic            port3_line6_oe_out,
  output logic            irq_t0_out,
  output logic            irq_t1_out,
  output logic            irq_out
);

  // ******************************************************************
  // Registers
  // ******************************************************************
  // Software-visible state and the flops behind the timer pin
  logic [7:0] timer_mode_reg_q;
  logic [7:0] reload0_q;
  logic [7:0] reload1_q;
  logic [7:0] pre0_q;
  logic [7:0] pre1_q;
  logic [1:0] run_q;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [7:0] rdata_q;
  logic [1:0] div4_q;
  logic       ext_q;
  logic       trig_arm_q;
  logic       tout_q;
  logic       tout_d;

  // Decoded strobes, clock sources and counter results
  wire        wr_mode;
  wire        wr_ctrl;
  wire [1:0]  load_cmd;
  wire [1:0]  run_next;
  wire [1:0]  run_set;
  wire [1:0]  run_stop;
  wire        int_tick;
  wire        ext_rise;
  wire [1:0]  ext_sel;
  wire        ext_used;
  wire        t1_src_tick;
  wire        t1_tick;
  wire        trig_ok;
  wire        trig_mode;
  wire        pre0_pulse;
  wire        pre1_pulse;
  wire [7:0]  count0;
  wire [7:0]  count1;
  wire        eoc0;
  wire        eoc1;
  wire        running0;
  wire        running1;
  wire [1:0]  eoc;
  wire [7:0]  rd_mux;

  // Address match, used for every write target
  // and the read select, kept in one place so both decode alike
  function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
    hit = (a == want);
  endfunction : hit

  // ******************************************************************
  // Write decode and commands
  // ******************************************************************
  assign wr_mode  = reg_write_in && hit(reg_addr_in, ADDR_MODE);
  assign wr_ctrl  = reg_write_in && hit(reg_addr_in, ADDR_CTRL);
  // Load bits are pulses; run bits are levels kept in run_q. A control
  // write with a run bit clear and its load bit clear stops that counter but keeps its count.
  assign load_cmd = wr_ctrl ? {reg_wdata_in[2+CTRL_LOAD], reg_wdata_in[CTRL_LOAD]} : 2'b00;
  assign run_next = wr_ctrl ? {reg_wdata_in[2+CTRL_RUN], reg_wdata_in[CTRL_RUN]} : run_q;

  // Configuration registers
  // Reload values only take effect at the next load or automatic reload
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      timer_mode_reg_q <= RESET_BYTE;
      reload0_q        <= RESET_BYTE;
      reload1_q        <= RESET_BYTE;
      pre0_q           <= RESET_BYTE;
      pre1_q           <= RESET_BYTE;
      mask_q           <= 2'b00;
    end else if (reg_write_in) begin
      if (hit(reg_addr_in, ADDR_MODE))    timer_mode_reg_q <= reg_wdata_in;
      if (hit(reg_addr_in, ADDR_RELOAD0)) reload0_q        <= reg_wdata_in;
      if (hit(reg_addr_in, ADDR_RELOAD1)) reload1_q        <= reg_wdata_in;
      if (hit(reg_addr_in, ADDR_PRE0))    pre0_q           <= reg_wdata_in;
      if (hit(reg_addr_in, ADDR_PRE1))    pre1_q           <= reg_wdata_in;
      if (hit(reg_addr_in, ADDR_MASK))    mask_q           <= reg_wdata_in[1:0];
    end
  end

  // Run levels: a load or an accepted trigger sets them, a single pass that
  // ends clears them. Both must agree with the counter's own run flag,
  // or the counter would be started again by a stale level.
  assign run_set  = {load_cmd[1] || trig_arm_q, load_cmd[0]};
  assign run_stop = {eoc1 && !pre1_q[PRE_CONT], eoc0 && !pre0_q[PRE_CONT]};

  // Run level register
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      run_q <= 2'b00;
    end else begin
      run_q <= (run_next & ~run_stop) | run_set;
    end
  end

  // ******************************************************************
  // Clock sources
  // ******************************************************************
  // Internal source is the system clock divided by four
  // Free running: a started counter may wait up to four cycles for a tick
  assign int_tick = (div4_q == 2'(INT_DIV - 1));
  // Port line is input only while the output driver is off
  assign ext_used = !timer_mode_reg_q[MODE_TOUT_EN];
  assign ext_rise = ext_used && port3_line6_in && !ext_q;
  assign ext_sel  = timer_mode_reg_q[MODE_EXT_LO +: 2];

  // Edge detect and trigger arming; inputs are synchronous already.
  // The edge register resets to the released, pulled-up pin level so that
  // leaving reset with the line idle high is not taken for a rising edge.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      div4_q     <= 2'b00;
      ext_q      <= 1'b1;
      trig_arm_q <= 1'b0;
    end else begin
      div4_q     <= div4_q + 2'b01;
      ext_q      <= port3_line6_in;
      // Non-retriggerable trigger is ignored while counter 1 runs
      trig_arm_q <= ext_rise && trig_ok;
    end
  end

  // Edges only arm the trigger in trigger mode; in clock or gate mode an
  // edge that also reloaded counter 1 would stop it from ever counting down.
  assign trig_mode = timer_mode_reg_q[MODE_T1_EXT] && (ext_sel == EXT_TRIGGER);
  assign trig_ok   = trig_mode && (timer_mode_reg_q[MODE_RETRIG] || !running1);
  // External modes: clock counts edges, gate qualifies internal ticks
  assign t1_src_tick = !timer_mode_reg_q[MODE_T1_EXT] ? int_tick :
                       (ext_sel == EXT_CLOCK) ? ext_rise :
                       (ext_sel == EXT_GATE)  ? (int_tick && port3_line6_in && ext_used) :
                       int_tick;
  // Cascade takes counter 0 end of count as the tick
  // through prescaler 1, so its ratio still divides the chained count
  assign t1_tick = timer_mode_reg_q[MODE_CASCADE] ? eoc0 : t1_src_tick;

  // ******************************************************************
  // Prescalers and counters
  // ******************************************************************
  // Loading a counter also clears its prescaler, so the first decrement
  // after a load comes a full prescaler period later, never a stray early one.
  dpct_prescaler #(.W(PRE_W)) u_pre0 (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .clear_in   (load_cmd[0]),
    .tick_in    (int_tick),
    .ratio_in   (pre0_q[PRE_DIV_LO +: PRE_W]),
    .pulse_out  (pre0_pulse)
  );

  dpct_prescaler #(.W(PRE_W)) u_pre1 (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .clear_in   (load_cmd[1] || trig_arm_q),
    .tick_in    (t1_tick),
    .ratio_in   (pre1_q[PRE_DIV_LO +: PRE_W]),
    .pulse_out  (pre1_pulse)
  );

  dpct_counter #(.W(CNT_W)) u_cnt0 (
    .clk_sys_in  (clk_sys_in),
    .reset_n_in  (reset_n_in),
    .load_in     (load_cmd[0]),
    .run_in      (run_next[0]),
    .cont_in     (pre0_q[PRE_CONT]),
    .dec_in      (pre0_pulse),
    .init_in     (reload0_q),
    .count_out   (count0),
    .eoc_out     (eoc0),
    .running_out (running0)
  );

  // Trigger mode: an accepted edge reloads and starts counter 1
  // and clears prescaler 1 with it, so the count starts from a clean period
  dpct_counter #(.W(CNT_W)) u_cnt1 (
    .clk_sys_in  (clk_sys_in),
    .reset_n_in  (reset_n_in),
    .load_in     (load_cmd[1] || trig_arm_q),
    .run_in      (run_next[1]),
    .cont_in     (pre1_q[PRE_CONT]),
    .dec_in      (pre1_pulse),
    .init_in     (reload1_q),
    .count_out   (count1),
    .eoc_out     (eoc1),
    .running_out (running1)
  );

  // ******************************************************************
  // Interrupts: sticky, write one to clear, set wins over clear
  // ******************************************************************
  // A clear written in the same cycle as a new end of count loses, so
  // software never misses an event it had not yet seen.
  assign eoc      = {eoc1, eoc0};
  assign status_d = (status_q & ~((reg_write_in && hit(reg_addr_in, ADDR_STATUS))
                    ? reg_wdata_in[1:0] : 2'b00)) | eoc;

  // Status flags
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      status_q <= 2'b00;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq_t0_out = status_q[0] && mask_q[0];
  assign irq_t1_out = status_q[1] && mask_q[1];
  assign irq_out    = irq_t0_out || irq_t1_out;

  // ******************************************************************
  // Timer output line
  // ******************************************************************
  // Counter outputs toggle at each end of count, a square wave at half the
  // end-of-count rate; the clock choice shows the divide-by-four phase, so
  // the pin never carries the full system clock.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      tout_q <= 1'b0;
    end else begin
      tout_q <= tout_d;
    end
  end

  // Any other select code parks the line low
  assign tout_d = (timer_mode_reg_q[MODE_TOUT_LO +: 2] == TOUT_SEL_T0)  ? tout_q ^ eoc0 :
                  (timer_mode_reg_q[MODE_TOUT_LO +: 2] == TOUT_SEL_T1)  ? tout_q ^ eoc1 :
                  (timer_mode_reg_q[MODE_TOUT_LO +: 2] == TOUT_SEL_CLK) ? div4_q[1] :
                  1'b0;
  assign port3_line6_out    = tout_q;
  assign port3_line6_oe_out = timer_mode_reg_q[MODE_TOUT_EN];

  // ******************************************************************
  // Read path: counts read live, prescalers never
  // ******************************************************************
  // Reload addresses read back the live count, not the value written; a
  // read never touches count or mode, so polling is always safe.
  assign rd_mux = hit(reg_addr_in, ADDR_MODE)    ? timer_mode_reg_q :
                  hit(reg_addr_in, ADDR_RELOAD0) ? count0 :
                  hit(reg_addr_in, ADDR_RELOAD1) ? count1 :
                  hit(reg_addr_in, ADDR_CTRL)    ? {4'h0, running1, 1'b0, running0, 1'b0} :
                  hit(reg_addr_in, ADDR_STATUS)  ? {6'h00, status_q} :
                  hit(reg_addr_in, ADDR_MASK)    ? {6'h00, mask_q} :
                  8'h00;

  // Read data stand only in the cycle after the strobe
  // and return to zero, so a stale byte can never be taken twice
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rdata_q <= RESET_BYTE;
    end else begin
      rdata_q <= reg_read_in ? rd_mux : RESET_BYTE;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule : dpct_timers

// ### verif/dpct_pin_model.sv
// Partner model of the timer pin seen from outside the block.
// Assumes the bench steers drv_in/lvl_in just after rising edges.
`timescale 1ns/1ps
module dpct_pin_model (
  input  wire logic oe_in,
  input  wire logic dout_in,
  input  wire logic drv_in,
  input  wire logic lvl_in,
  output logic      pin_out
);
  // Block wins while it drives; released line floats to the pull-up
  assign pin_out = oe_in ? dout_in : (drv_in ? lvl_in : 1'b1);
endmodule : dpct_pin_model

// ### verif/dpct_timers_assertions.sv
// Checker for the dual counter/timer top module ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module dpct_timers_checker
  import dpct_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_write_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       port3_line6_in,
  input wire logic       port3_line6_out,
  input wire logic       port3_line6_oe_out,
  input wire logic       irq_t0_out,
  input wire logic       irq_t1_out,
  input wire logic       irq_out
);
  // ****************************************
  // Shadow copies of mode and mask
  // ****************************************
  logic [7:0] mode_q;
  logic [1:0] mask_q;
  logic       clk_sel;
  assign clk_sel = port3_line6_oe_out && (mode_q[1:0] == TOUT_SEL_CLK);
  // Shadows follow the same writes the block takes
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      mode_q <= 8'h00;
      mask_q <= 2'h0;
    end else if (reg_write_in && reg_addr_in == ADDR_MODE) begin
      mode_q <= reg_wdata_in;
    end else if (reg_write_in && reg_addr_in == ADDR_MASK) begin
      mask_q <= reg_wdata_in[1:0];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // ****************************************
  // Properties
  // ****************************************
  sequence s_wr(logic [3:0] a);
    reg_write_in && reg_addr_in == a;
  endsequence
  sequence s_rd(logic [3:0] a);
    reg_read_in && reg_addr_in == a;
  endsequence
  property p_irq_or;
    irq_out == (irq_t0_out | irq_t1_out);
  endproperty
  property p_rd_idle;
    !reg_read_in |=> reg_rdata_out == 8'h00;
  endproperty
  property p_pre_hidden;
    reg_read_in && (reg_addr_in == ADDR_PRE0 || reg_addr_in == ADDR_PRE1)
      |=> reg_rdata_out == 8'h00;
  endproperty
  property p_unmapped;
    reg_read_in && reg_addr_in[3] |=> reg_rdata_out == 8'h00;
  endproperty
  property p_oe_mode;
    s_wr(ADDR_MODE) |=> port3_line6_oe_out == $past(reg_wdata_in[MODE_TOUT_EN]);
  endproperty
  property p_oe_hold;
    !(reg_write_in && reg_addr_in == ADDR_MODE) |=> $stable(port3_line6_oe_out);
  endproperty
  property p_mask_gate;
    (irq_t0_out |-> mask_q[0]) and (irq_t1_out |-> mask_q[1]);
  endproperty
  property p_irq_fall;
    $fell(irq_t0_out) |-> $past(reg_write_in)
      && ($past(reg_addr_in) == ADDR_STATUS || $past(reg_addr_in) == ADDR_MASK);
  endproperty
  property p_ctrl_rd;
    s_rd(ADDR_CTRL) |=> reg_rdata_out[7:4] == 4'h0 && !reg_rdata_out[0]
      && !reg_rdata_out[2];
  endproperty
  property p_tout_clk;
    clk_sel && $past(clk_sel, 3) |-> port3_line6_out != $past(port3_line6_out, 2);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq or wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_pre_hidden: assert property (p_pre_hidden) else $error("prescaler readable");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_oe_mode: assert property (p_oe_mode) else $error("oe not from mode");
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  a_mask_gate: assert property (p_mask_gate) else $error("masked irq high");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read bits");
  a_tout_clk: assert property (p_tout_clk) else $error("clock out stuck");
endmodule : dpct_timers_checker

bind dpct_timers dpct_timers_checker u_chk (.clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .port3_line6_in(port3_line6_in), .port3_line6_out(port3_line6_out),
  .port3_line6_oe_out(port3_line6_oe_out), .irq_t0_out(irq_t0_out),
  .irq_t1_out(irq_t1_out), .irq_out(irq_out));

// ### verif/tb_dpct_timers.sv
// Self-checking bench for the dual counter/timer block.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/1ps
module tb_dpct_timers
  import dpct_pkg::*;
;
  logic       clk, rst_n, we, re, drv, lvl, pin, p_out, p_oe, irq0, irq1, irq, x;
  logic [3:0] addr;
  logic [7:0] wd, rdata, rv;
  int         bad_count, num_checks, cyc, n;
  int         tab [4][3] = '{'{3, 1, 12}, '{2, 2, 16}, '{1, 0, 256}, '{0, 1, 1024}};

  dpct_timers dut (.clk_sys_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdata),
    .port3_line6_in(pin), .port3_line6_out(p_out), .port3_line6_oe_out(p_oe),
    .irq_t0_out(irq0), .irq_t1_out(irq1), .irq_out(irq));
  dpct_pin_model u_pin (.oe_in(p_oe), .dout_in(p_out), .drv_in(drv), .lvl_in(lvl),
    .pin_out(pin));

  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run is under 3000 cycles; the ceiling leaves room
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      stop_test();
    end
  end

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(logic [3:0] a, logic [7:0] d);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [3:0] a);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 rv = rdata;
    @(posedge clk);
  endtask : rd
  task automatic wait_irq(int w, int lim);
    n = 0;
    #1;
    while (!(w ? irq1 : irq0) && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_irq
  task automatic pulse();
    lvl <= 1'b1;
    repeat (3) @(posedge clk);
    lvl <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n, we, re, drv, lvl, addr, wd, bad_count, num_checks, cyc} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("irq reset", {6'h0, irq, p_oe}, 8'h00);
    rd(ADDR_STATUS); check("status reset", rv, 8'h00);
    rd(4'hF); check("unmapped", rv, 8'h00);
    wr(ADDR_MASK, 8'h03);
    // Single pass lengths: ratio 1..64, loads 1..256
    foreach (tab[i]) begin
      wr(ADDR_PRE0, 8'(tab[i][1]));
      wr(ADDR_RELOAD0, 8'(tab[i][0]));
      wr(ADDR_CTRL, 8'h03);
      wait_irq(0, tab[i][2] + 20);
      check("t0 span", 8'(n >= tab[i][2] - 4 && n <= tab[i][2] + 6), 8'h01);
      check("irq pair", {6'h0, irq1, irq0}, 8'h01);
      rd(ADDR_RELOAD0); check("t0 halt", rv, 8'h00);
      rd(ADDR_CTRL); check("t0 stopped", rv, 8'h00);
      wr(ADDR_MASK, 8'h02); check("masked", {7'h0, irq}, 8'h00);
      rd(ADDR_STATUS); check("sticky", rv, 8'h01);
      wr(ADDR_MASK, 8'h03);
      wr(ADDR_STATUS, 8'h01); check("cleared", {7'h0, irq}, 8'h00);
    end
    // Continuous mode, then stop and continue
    wr(ADDR_PRE0, 8'h41);
    wr(ADDR_RELOAD0, 8'h02);
    wr(ADDR_CTRL, 8'h03);
    wait_irq(0, 30);
    wr(ADDR_STATUS, 8'h01);
    wait_irq(0, 14); check("t0 again", {7'h0, irq0}, 8'h01);
    rd(ADDR_CTRL); check("t0 runs", rv, 8'h02);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_RELOAD0);
    x = rv[0];
    n = rv;
    repeat (4) rd(ADDR_RELOAD0);
    check("held", rv, 8'(n));
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL); check("resumed", rv, 8'h02);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_STATUS, 8'h01);
    // Counter 1 on pin edges
    drv <= 1'b1;
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_PRE1, 8'h01);
    wr(ADDR_RELOAD1, 8'h03);
    wr(ADDR_CTRL, 8'h0C);
    repeat (2) pulse();
    rd(ADDR_RELOAD1); check("t1 ext", rv, 8'h01);
    check("t1 early", {7'h0, irq1}, 8'h00);
    pulse();
    wait_irq(1, 10); check("t1 eoc", {6'h0, irq1, irq0}, 8'h02);
    // Gate on the internal divided clock
    wr(ADDR_STATUS, 8'h02);
    wr(ADDR_MODE, 8'h48);
    wr(ADDR_RELOAD1, 8'h02);
    wr(ADDR_CTRL, 8'h0C);
    repeat (5) rd(ADDR_RELOAD1);
    check("gate shut", rv, 8'h02);
    lvl <= 1'b1;
    wait_irq(1, 20); check("gate open", 8'(irq1 && n >= 4 && n <= 12), 8'h01);
    // Trigger edge starts counter 1
    lvl <= 1'b0;
    wr(ADDR_STATUS, 8'h02);
    wr(ADDR_MODE, 8'h54);
    rd(ADDR_CTRL); check("idle", rv, 8'h00);
    pulse();
    rd(ADDR_CTRL); check("triggered", {7'h0, rv[3]}, 8'h01);
    wait_irq(1, 16); check("trig eoc", {7'h0, irq1}, 8'h01);
    // Cascade: counter 1 steps on counter 0 ends
    wr(ADDR_MODE, 8'hA0);
    drv <= 1'b0;
    wr(ADDR_PRE0, 8'h42);
    wr(ADDR_RELOAD0, 8'h01);
    wr(ADDR_RELOAD1, 8'h02);
    wr(ADDR_STATUS, 8'h03);
    rd(ADDR_PRE0); check("pre hidden", rv, 8'h00);
    x = p_out;
    wr(ADDR_CTRL, 8'h0F);
    wait_irq(1, 40); check("cascade", 8'(irq1 && n >= 12), 8'h01);
    check("tout t0", {7'h0, p_out}, {7'h0, x});
    check("pin out", {6'h0, pin, p_oe}, {6'h0, p_out, 1'b1});
    wr(ADDR_MODE, 8'h82);
    repeat (8) @(posedge clk);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h00); check("parked", {7'h0, p_oe}, 8'h00);
    stop_test();
  end
endmodule : tb_dpct_timers
